// ==== verilog/vpd_dispatcher.sv ====
// Vocoder packet dispatcher: packet parse, routing, ordering and reply framing
// What this block does
// - In codec mode, exchange one converter sample every 125 us
// - Samples are 16-bit two's-complement, full scale
// - Samples pass to and from coder unscaled
// - Converter setup from pins or software, as chosen
// - Packets only, port chosen by strap pins
// - Header is start, length, type
// - Received packets handled strictly in order
// - Codec mode sends channel packet every 20 ms
// - Codec cadence counted from converter sample clock
// - Speech packets accepted only in packet mode
// - Packet mode replies as soon as ready
// - Replies leave in request order
// - Queues hold two speech plus two channel
// - Port keeps moving while at most two replies are pending, stalls at three
// - Speech packet yields a channel reply
// - Channel packet yields a speech reply
// - Config packet applied, then config reply
// - Start byte is 0x61, else ignored
// - Two-byte length, MSB first, excludes header
// - Types: 0x00 config, 0x01 channel, 0x02 speech
// - Parity marker 0x2F plus byte, on after reset
`timescale 1ns/1ps
`include "vpd_defines.svh"

module vpd_dispatcher import vpd_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire logic [1:0] port_sel_i,
	output logic [1:0] active_port_o,
	input wire logic codec_mode_i,
	output logic codec_mode_o,
	input wire logic conv_fs_i,
	input wire logic [15:0] conv_adc_i,
	output logic [15:0] conv_dac_o,
	input wire logic conv_cfg_src_i,
	input wire logic [7:0] conv_cfg_pins_i,
	output logic [7:0] conv_cfg_o,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_data_i,
	input wire logic parity_we_i,
	input wire logic parity_en_i,
	output logic parity_on_o,
	output logic [15:0] enc_sample_o,
	output logic enc_valid_o,
	output logic [7:0] chan_byte_o,
	output logic chan_valid_o,
	output logic [7:0] cfg_byte_o,
	output logic cfg_valid_o,
	input wire logic [15:0] dec_sample_i,
	input wire logic dec_valid_i,
	input wire logic [15:0] res_len_i,
	input wire logic [7:0] res_byte_i,
	input wire logic res_valid_i,
	output logic res_ready_o,
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic pkt_done_o,
	output logic pkt_err_o
);
	// Reply type for each request type
	function automatic vpd_resp_t resp_for(input logic [7:0] t);
		case (t)
			`VPD_TYPE_SPEECH: resp_for = RESP_CHAN;
			`VPD_TYPE_CHAN: resp_for = RESP_SPEECH;
			default: resp_for = RESP_CFG;
		endcase
	endfunction : resp_for

	function automatic logic [7:0] resp_byte(input vpd_resp_t r);
		case (r)
			RESP_CHAN: resp_byte = `VPD_TYPE_CHAN;
			RESP_SPEECH: resp_byte = `VPD_TYPE_SPEECH;
			default: resp_byte = `VPD_TYPE_CFG;
		endcase
	endfunction : resp_byte

	// Types accepted in the current mode
	function automatic logic type_good(input logic [7:0] t, input logic cm);
		type_good = (t == `VPD_TYPE_CFG) || (t == `VPD_TYPE_CHAN) || ((t == `VPD_TYPE_SPEECH) && !cm);
	endfunction : type_good

	// Pin synchronisers
	logic [1:0] port_m, port_s;
	logic mode_m, mode_s, src_m, src_s;
	logic fs_m, fs_s, fs_d;
	logic [15:0] adc_m, adc_s;
	logic [7:0] pins_m, pins_s;
	logic strap_done;

	always_ff @(posedge clk_i) begin
		port_m <= port_sel_i;
		port_s <= port_m;
		mode_m <= codec_mode_i;
		mode_s <= mode_m;
		src_m <= conv_cfg_src_i;
		src_s <= src_m;
		fs_m <= conv_fs_i;
		fs_s <= fs_m;
		adc_m <= conv_adc_i;
		adc_s <= adc_m;
		pins_m <= conv_cfg_pins_i;
		pins_s <= pins_m;
	end

	// Straps caught once, after synchroniser settles
	logic [1:0] strap_wait;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_wait <= 2'h0;
			strap_done <= 1'b0;
			active_port_o <= 2'h0;
			codec_mode_o <= 1'b0;
		end else if (!strap_done) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == 2'h3) begin
				strap_done <= 1'b1;
				active_port_o <= port_s;
				codec_mode_o <= mode_s;
			end
		end
	end

	// Converter setup source
	logic [7:0] sw_cfg;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sw_cfg <= 8'h00;
			conv_cfg_o <= 8'h00;
		end else begin
			if (cfg_we_i) begin
				sw_cfg <= cfg_data_i;
			end
			conv_cfg_o <= src_s ? sw_cfg : pins_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			parity_on_o <= `VPD_PARITY_RST;
		end else if (parity_we_i) begin
			parity_on_o <= parity_en_i;
		end
	end

	// Sample clock cadence
	logic fs_tick;
	logic [7:0] frame_cnt;
	logic codec_pend;
	logic ord_push_rx;
	vpd_resp_t ord_push_rx_type;
	logic ord_full;
	assign fs_tick = fs_s && !fs_d;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fs_d <= 1'b0;
			frame_cnt <= 8'h00;
			codec_pend <= 1'b0;
		end else begin
			fs_d <= fs_s;
			if (codec_pend && !ord_push_rx && !ord_full) begin
				codec_pend <= 1'b0;
			end
			// New frame wins over the clear of the one just queued
			if (codec_mode_o && fs_tick) begin
				if (frame_cnt == 8'(`VPD_FRAME_SAMPLES - 1)) begin
					frame_cnt <= 8'h00;
					codec_pend <= 1'b1;
				end else begin
					frame_cnt <= frame_cnt + 8'h01;
				end
			end
		end
	end

	// Receive parser
	vpd_rx_state_t rx_state;
	logic [15:0] rx_len, rx_remain;
	logic [7:0] rx_type, rx_par;
	logic rx_bad, rx_hi_half;
	logic [7:0] rx_hi;
	logic rx_take;
	logic [15:0] body_len;
	logic type_ok;
	assign rx_take = rx_valid_i && rx_ready_o;
	assign body_len = parity_on_o ? rx_len - `VPD_PARITY_LEN : rx_len;
	assign type_ok = type_good(rx_type, codec_mode_o);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_state <= RX_HUNT;
			rx_len <= 16'h0000;
			rx_remain <= 16'h0000;
			rx_type <= 8'h00;
			rx_par <= 8'h00;
			rx_bad <= 1'b0;
			ord_push_rx <= 1'b0;
			ord_push_rx_type <= RESP_CFG;
			pkt_done_o <= 1'b0;
			pkt_err_o <= 1'b0;
		end else begin
			ord_push_rx <= 1'b0;
			pkt_done_o <= 1'b0;
			pkt_err_o <= 1'b0;
			if (rx_take) begin
				case (rx_state)
					RX_HUNT: begin
						if (rx_byte_i == `VPD_START_BYTE) begin
							rx_state <= RX_LENH;
							rx_par <= 8'h00;
							rx_bad <= 1'b0;
						end
					end
					RX_LENH: begin
						rx_len[15:8] <= rx_byte_i;
						rx_par <= rx_par ^ rx_byte_i;
						rx_state <= RX_LENL;
					end
					RX_LENL: begin
						rx_len[7:0] <= rx_byte_i;
						rx_par <= rx_par ^ rx_byte_i;
						rx_state <= RX_TYPE;
					end
					RX_TYPE: begin
						rx_type <= rx_byte_i;
						rx_par <= rx_par ^ rx_byte_i;
						rx_remain <= body_len;
						if (parity_on_o && rx_len < `VPD_PARITY_LEN) begin
							rx_bad <= 1'b1;
						end
						if (body_len == 16'h0000 || (parity_on_o && rx_len < `VPD_PARITY_LEN)) begin
							rx_state <= parity_on_o ? RX_PMARK : RX_HUNT;
							if (!parity_on_o) begin
								ord_push_rx <= type_good(rx_byte_i, codec_mode_o);
								ord_push_rx_type <= resp_for(rx_byte_i);
								pkt_done_o <= type_good(rx_byte_i, codec_mode_o);
								pkt_err_o <= !type_good(rx_byte_i, codec_mode_o);
							end
						end else begin
							rx_state <= RX_BODY;
						end
					end
					RX_BODY: begin
						rx_par <= rx_par ^ rx_byte_i;
						rx_remain <= rx_remain - 16'h0001;
						if (rx_remain == 16'h0001) begin
							rx_state <= parity_on_o ? RX_PMARK : RX_HUNT;
							if (!parity_on_o) begin
								ord_push_rx <= type_ok;
								ord_push_rx_type <= resp_for(rx_type);
								pkt_done_o <= type_ok;
								pkt_err_o <= !type_ok;
							end
						end
					end
					RX_PMARK: begin
						rx_par <= rx_par ^ rx_byte_i;
						rx_bad <= rx_bad || (rx_byte_i != `VPD_PMARK_BYTE);
						rx_state <= RX_PBYTE;
					end
					RX_PBYTE: begin
						rx_state <= RX_HUNT;
						ord_push_rx <= type_ok && !rx_bad && (rx_byte_i == rx_par);
						ord_push_rx_type <= resp_for(rx_type);
						pkt_done_o <= type_ok && !rx_bad && (rx_byte_i == rx_par);
						pkt_err_o <= !(type_ok && !rx_bad && (rx_byte_i == rx_par));
					end
					default: rx_state <= RX_HUNT;
				endcase
			end
		end
	end

	// Payload routing toward encoder, decoder and config handling
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			enc_sample_o <= 16'h0000;
			enc_valid_o <= 1'b0;
			chan_byte_o <= 8'h00;
			chan_valid_o <= 1'b0;
			cfg_byte_o <= 8'h00;
			cfg_valid_o <= 1'b0;
			rx_hi_half <= 1'b1;
			rx_hi <= 8'h00;
		end else begin
			enc_valid_o <= 1'b0;
			chan_valid_o <= 1'b0;
			cfg_valid_o <= 1'b0;
			if (rx_take && rx_state == RX_TYPE) begin
				rx_hi_half <= 1'b1;
			end
			if (codec_mode_o && fs_tick) begin
				enc_sample_o <= adc_s;
				enc_valid_o <= 1'b1;
			end
			// Channel and config bytes still routed on a sample tick
			if (rx_take && rx_state == RX_BODY && type_ok) begin
				case (rx_type)
					`VPD_TYPE_SPEECH: begin
						rx_hi_half <= !rx_hi_half;
						if (rx_hi_half) begin
							rx_hi <= rx_byte_i;
						end else begin
							enc_sample_o <= {rx_hi, rx_byte_i};
							enc_valid_o <= 1'b1;
						end
					end
					`VPD_TYPE_CHAN: begin
						chan_byte_o <= rx_byte_i;
						chan_valid_o <= 1'b1;
					end
					default: begin
						cfg_byte_o <= rx_byte_i;
						cfg_valid_o <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			conv_dac_o <= 16'h0000;
		end else if (codec_mode_o && dec_valid_i) begin
			conv_dac_o <= dec_sample_i;
		end
	end

	// Reply order queue
	vpd_resp_t ord_mem [`VPD_ORD_DEPTH];
	logic [1:0] ord_wr, ord_rd;
	logic [2:0] ord_cnt;
	logic ord_push, ord_pop;
	vpd_resp_t ord_in;
	assign ord_full = (ord_cnt == 3'(`VPD_ORD_DEPTH));
	assign ord_push = (ord_push_rx || codec_pend) && !ord_full;
	assign ord_in = ord_push_rx ? ord_push_rx_type : RESP_CHAN;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ord_wr <= 2'h0;
			ord_rd <= 2'h0;
			ord_cnt <= 3'h0;
			rx_ready_o <= 1'b0;
			for (int i = 0; i < `VPD_ORD_DEPTH; i++) begin
				ord_mem[i] <= RESP_CFG;
			end
		end else begin
			if (ord_push) begin
				ord_mem[ord_wr] <= ord_in;
				ord_wr <= ord_wr + 2'h1;
			end
			if (ord_pop) begin
				ord_rd <= ord_rd + 2'h1;
			end
			ord_cnt <= ord_cnt + 3'(ord_push) - 3'(ord_pop);
			rx_ready_o <= strap_done && (ord_cnt < 3'(`VPD_ORD_DEPTH - 1));
		end
	end

	// Reply framer
	vpd_tx_state_t tx_state;
	logic [15:0] tx_len, tx_remain;
	logic [7:0] tx_par, tx_push_data;
	logic tx_push, tx_par_on, buf_in_ready, can_push;
	vpd_resp_t tx_type;
	assign can_push = buf_in_ready && !tx_push;
	assign ord_pop = (tx_state == TX_IDLE) && (ord_cnt != 3'h0) && res_valid_i;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_state <= TX_IDLE;
			tx_len <= 16'h0000;
			tx_remain <= 16'h0000;
			tx_par <= 8'h00;
			tx_par_on <= 1'b1;
			tx_type <= RESP_CFG;
			tx_push <= 1'b0;
			tx_push_data <= 8'h00;
			res_ready_o <= 1'b0;
		end else begin
			tx_push <= 1'b0;
			res_ready_o <= 1'b0;
			case (tx_state)
				TX_IDLE: begin
					if (ord_pop) begin
						tx_type <= ord_mem[ord_rd];
						tx_par_on <= parity_on_o;
						tx_remain <= res_len_i;
						tx_len <= res_len_i + (parity_on_o ? `VPD_PARITY_LEN : 16'h0000);
						tx_par <= 8'h00;
						tx_state <= TX_START;
					end
				end
				TX_START: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= `VPD_START_BYTE;
					tx_state <= TX_LENH;
				end
				TX_LENH: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= tx_len[15:8];
					tx_par <= tx_par ^ tx_len[15:8];
					tx_state <= TX_LENL;
				end
				TX_LENL: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= tx_len[7:0];
					tx_par <= tx_par ^ tx_len[7:0];
					tx_state <= TX_TYPE;
				end
				TX_TYPE: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= resp_byte(tx_type);
					tx_par <= tx_par ^ resp_byte(tx_type);
					tx_state <= (tx_remain != 16'h0000) ? TX_BODY : (tx_par_on ? TX_PMARK : TX_IDLE);
				end
				TX_BODY: begin
					if (res_ready_o && res_valid_i) begin
						tx_push <= 1'b1;
						tx_push_data <= res_byte_i;
						tx_par <= tx_par ^ res_byte_i;
						tx_remain <= tx_remain - 16'h0001;
						if (tx_remain == 16'h0001) begin
							tx_state <= tx_par_on ? TX_PMARK : TX_IDLE;
						end
					end else if (!res_ready_o && can_push) begin
						res_ready_o <= 1'b1;
					end
				end
				TX_PMARK: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= `VPD_PMARK_BYTE;
					tx_par <= tx_par ^ `VPD_PMARK_BYTE;
					tx_state <= TX_PBYTE;
				end
				TX_PBYTE: if (can_push) begin
					tx_push <= 1'b1;
					tx_push_data <= tx_par;
					tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Stall by the port holds the framer, no byte lost
	vpd_two_buf #(
		.W(`VPD_BUF_WIDTH)
	) u_tx_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_data_i(tx_push_data),
		.in_valid_i(tx_push),
		.in_ready_o(buf_in_ready),
		.out_data_o(tx_byte_o),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i)
	);

endmodule : vpd_dispatcher

// ==== verilog/vpd_defines.svh ====
// Constants for the vocoder packet dispatcher
`ifndef VPD_DEFINES_SVH
`define VPD_DEFINES_SVH

// Packet framing bytes
`define VPD_START_BYTE 8'h61
`define VPD_PMARK_BYTE 8'h2F
`define VPD_TYPE_CFG 8'h00
`define VPD_TYPE_CHAN 8'h01
`define VPD_TYPE_SPEECH 8'h02
`define VPD_PARITY_LEN 16'h0002
`define VPD_PARITY_RST 1'b1

// Sample and frame timing
`define VPD_CLK_PERIOD_NS 100
`define VPD_SAMPLE_PERIOD_US 125
`define VPD_FRAME_MS 20
`define VPD_FRAME_SAMPLES ((`VPD_FRAME_MS * 1000) / `VPD_SAMPLE_PERIOD_US)
`define VPD_SAMPLE_CYCLES ((`VPD_SAMPLE_PERIOD_US * 1000) / `VPD_CLK_PERIOD_NS)

// Queue sizes: two speech plus two channel packets
`define VPD_ORD_DEPTH 4
`define VPD_BUF_WIDTH 8

`endif

// ==== verilog/vpd_pkg.sv ====
// Types for the vocoder packet dispatcher
package vpd_pkg;

	typedef enum logic [2:0] {
		RX_HUNT = 3'b000,
		RX_LENH = 3'b001,
		RX_LENL = 3'b010,
		RX_TYPE = 3'b011,
		RX_BODY = 3'b100,
		RX_PMARK = 3'b101,
		RX_PBYTE = 3'b110
	} vpd_rx_state_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_LENH = 3'b010,
		TX_LENL = 3'b011,
		TX_TYPE = 3'b100,
		TX_BODY = 3'b101,
		TX_PMARK = 3'b110,
		TX_PBYTE = 3'b111
	} vpd_tx_state_t;

	typedef enum logic [1:0] {
		RESP_CFG = 2'b00,
		RESP_CHAN = 2'b01,
		RESP_SPEECH = 2'b10
	} vpd_resp_t;

endpackage : vpd_pkg

// ==== verilog/vpd_two_buf.sv ====
// Two-entry valid/ready buffer on the transmit byte path
`timescale 1ns/1ps
`include "vpd_defines.svh"

module vpd_two_buf #(
	parameter int W = `VPD_BUF_WIDTH
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	logic [W-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic [1:0] next_count;
	logic do_push;
	logic do_pop;

	assign do_push = in_valid_i && in_ready_o;
	assign do_pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (do_push && !do_pop) begin
			next_count = count + 2'h1;
		end else if (do_pop && !do_push) begin
			next_count = count - 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count <= 2'h0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			count <= next_count;
			in_ready_o <= (next_count != 2'h2);
			out_valid_o <= (next_count != 2'h0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			mem[0] <= '0;
			mem[1] <= '0;
		end else begin
			if (do_push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop) begin
				rd_ptr <= ~rd_ptr;
			end
		end
	end

endmodule : vpd_two_buf

// ==== test/vpd_checker.sv ====
// Port assertions for the vocoder packet dispatcher
`timescale 1ns/1ps
module vpd_checker (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	input wire logic rx_ready_o,
	input wire logic [1:0] port_sel_i,
	input wire logic [1:0] active_port_o,
	input wire logic codec_mode_i,
	input wire logic codec_mode_o,
	input wire logic conv_cfg_src_i,
	input wire logic [7:0] conv_cfg_pins_i,
	input wire logic [7:0] conv_cfg_o,
	input wire logic parity_on_o,
	input wire logic enc_valid_o,
	input wire logic [7:0] chan_byte_o,
	input wire logic chan_valid_o,
	input wire logic [7:0] cfg_byte_o,
	input wire logic cfg_valid_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic pkt_done_o,
	input wire logic pkt_err_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
		else $error("stalled reply byte moved");
	reset_state_a: assert property ($fell(sys_rst_i) |-> parity_on_o && !rx_ready_o && !tx_valid_o)
		else $error("bad state after reset");
	strap_latch_a: assert property ($rose(rx_ready_o) |-> active_port_o == port_sel_i && codec_mode_o == codec_mode_i)
		else $error("straps not latched");
	setup_src_a: assert property ((!conv_cfg_src_i && $stable(conv_cfg_pins_i)) [*4] |-> conv_cfg_o == conv_cfg_pins_i)
		else $error("pin setup not selected");
	chan_fwd_a: assert property (chan_valid_o |-> $past(rx_valid_i && rx_ready_o) && chan_byte_o == $past(rx_byte_i))
		else $error("channel byte not forwarded");
	cfg_fwd_a: assert property (cfg_valid_o |-> $past(rx_valid_i && rx_ready_o) && cfg_byte_o == $past(rx_byte_i))
		else $error("config byte not forwarded");
	enc_gap_a: assert property (codec_mode_o && enc_valid_o |=> !enc_valid_o [*8])
		else $error("samples closer than one frame sync");
	pkt_gap_a: assert property (pkt_done_o || pkt_err_o |=> !(pkt_done_o || pkt_err_o) [*3])
		else $error("packet ends too close");

	cover property (pkt_err_o);
	cover property (tx_valid_o && !tx_ready_i);
	cover property (codec_mode_o && enc_valid_o);
endmodule : vpd_checker

bind vpd_dispatcher vpd_checker u_chk (.*);

// ==== test/vpd_host_model.sv ====
// Host-side partner: result byte source and reply byte sink, both stalling
`timescale 1ns/1ps
module vpd_host_model #(
	parameter int RLEN = 3
) (
	input wire logic clk_i,
	input wire logic res_ready_i,
	output logic [15:0] res_len_o,
	output logic [7:0] res_byte_o,
	output logic res_valid_o,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o
);
	logic [7:0] got[$];
	logic [7:0] nxt = 8'h00;
	assign res_len_o = 16'(RLEN);
	// Idle data line shows the inverse, never a stale byte
	assign res_byte_o = res_valid_o ? nxt : ~nxt;
	initial begin
		res_valid_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
		if (res_valid_o && res_ready_i) nxt <= nxt + 8'h01;
		// Offered result byte held until taken
		if (!res_valid_o || res_ready_i) res_valid_o <= ($urandom % 3) != 0;
		tx_ready_o <= ($urandom % 4) != 0;
	end
endmodule : vpd_host_model

// ==== test/vocoder_packet_dispatcher_tb.sv ====
// Self-checking bench for the vocoder packet dispatcher
`timescale 1ns/1ps
module vocoder_packet_dispatcher_tb;
	localparam int RLEN = 3;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, rx_valid_i = 1'b0, codec_mode_i = 1'b0, conv_fs_i = 1'b0;
	logic conv_cfg_src_i = 1'b0, cfg_we_i = 1'b0, parity_we_i = 1'b0, parity_en_i = 1'b0, dec_valid_i = 1'b0;
	logic [1:0] port_sel_i = 2'h1;
	logic [7:0] rx_byte_i = 8'h00, conv_cfg_pins_i = 8'h3C, cfg_data_i = 8'h00;
	logic [15:0] conv_adc_i = 16'h0000, dec_sample_i = 16'h0000;
	logic rx_ready_o, codec_mode_o, parity_on_o, enc_valid_o, chan_valid_o, cfg_valid_o, res_valid_i;
	logic res_ready_o, tx_valid_o, tx_ready_i, pkt_done_o, pkt_err_o;
	logic [1:0] active_port_o;
	logic [7:0] conv_cfg_o, chan_byte_o, cfg_byte_o, res_byte_i, tx_byte_o;
	logic [15:0] conv_dac_o, enc_sample_o, res_len_i;
	int n_fail = 0, compares = 0, n_err = 0, n_ok = 0, cyc = 0, rb = 0;
	logic par = 1'b1;
	logic [7:0] exp_q[$], cfgb[$], body[$];
	logic [15:0] enc_q[$];

	vpd_host_model #(.RLEN(RLEN)) host (
		.clk_i(clk_i),
		.res_ready_i(res_ready_o),
		.res_len_o(res_len_i),
		.res_byte_o(res_byte_i),
		.res_valid_o(res_valid_i),
		.tx_byte_i(tx_byte_o),
		.tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i)
	);
	vpd_dispatcher DUT (.*);

	always #50 clk_i = ~clk_i;

	task automatic finish_test;
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s %h, expected %h", $time, msg, got, exp);
		end
	endtask : check

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			finish_test();
		end
		if (pkt_err_o === 1'b1) n_err++;
		if (pkt_done_o === 1'b1) n_ok++;
		if (enc_valid_o === 1'b1) check(enc_sample_o, codec_mode_o ? conv_adc_i : enc_q.pop_front(), "sample");
	end

	// Offer one byte, hold it until taken, sometimes pause after
	task automatic put(input logic [7:0] b);
		rx_byte_i <= b;
		rx_valid_i <= 1'b1;
		do @(posedge clk_i); while (rx_ready_o !== 1'b1);
		if ($urandom % 3 == 0) begin
			rx_valid_i <= 1'b0;
			rx_byte_i <= ~b;
			@(posedge clk_i);
		end
	endtask : put

	// Length stays below 256 here, so its upper byte is zero
	task automatic send(input logic [7:0] typ, input logic [7:0] bd[$], input logic good);
		logic [7:0] p;
		p = 8'(bd.size() + 2) ^ typ ^ 8'h2F;
		put(8'h61);
		put(8'h00);
		put(8'(bd.size() + (par ? 2 : 0)));
		put(typ);
		foreach (bd[i]) begin
			put(bd[i]);
			p ^= bd[i];
		end
		if (par) begin
			put(8'h2F);
			put(good ? p : ~p);
		end
		rx_valid_i <= 1'b0;
		rx_byte_i <= ~rx_byte_i;
		@(posedge clk_i);
	endtask : send

	function automatic void want(input logic [7:0] typ);
		logic [7:0] p;
		p = 8'(RLEN + 2) ^ typ ^ 8'h2F;
		exp_q.push_back(8'h61);
		exp_q.push_back(8'h00);
		exp_q.push_back(8'(RLEN + (par ? 2 : 0)));
		exp_q.push_back(typ);
		repeat (RLEN) begin
			exp_q.push_back(8'(rb));
			p ^= 8'(rb);
			rb++;
		end
		if (par) begin
			exp_q.push_back(8'h2F);
			exp_q.push_back(p);
		end
	endfunction : want

	task automatic drain;
		int w = 0;
		@(negedge clk_i);
		while (host.got.size() < exp_q.size() && w < 4000) begin
			@(negedge clk_i);
			w++;
		end
		check(16'(host.got.size()), 16'(exp_q.size()), "reply count");
		foreach (exp_q[i]) check(16'(host.got[i]), 16'(exp_q[i]), "reply byte");
		exp_q = {};
		host.got = {};
		@(posedge clk_i);
	endtask : drain

	initial begin
		logic [7:0] t;
		void'($urandom(52763));
		cfgb = '{8'h01, 8'h41, 8'h02, 8'hA0, 8'h04, 8'h83, 8'h05, 8'hB8, 8'h06, 8'h02};
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		put(8'h5A);
		send(8'h00, cfgb, 1'b1);
		want(8'h00);
		drain();
		check(16'(active_port_o), 16'h0001, "port strap");
		for (int i = 0; i < 12; i++) begin
			t = 8'($urandom % 3);
			body = {};
			repeat (2 * ($urandom % 4 + 1)) body.push_back(8'($urandom));
			if (t == 8'h02) begin
				for (int k = 0; k < body.size(); k += 2) enc_q.push_back({body[k], body[k + 1]});
			end
			send(t, body, 1'b1);
			want(t == 8'h00 ? 8'h00 : 8'h03 - t);
			if (i % 2 == 1) drain();
		end
		body = '{8'h12, 8'h34};
		send(8'h01, body, 1'b0);
		send(8'h03, body, 1'b1);
		send(8'h01, body, 1'b1);
		want(8'h02);
		drain();
		check(16'(n_err), 16'h0002, "dropped packets");
		check(16'(n_ok), 16'h000E, "accepted packets");
		conv_cfg_src_i <= 1'b1;
		cfg_data_i <= 8'($urandom);
		cfg_we_i <= 1'b1;
		@(posedge clk_i);
		cfg_we_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(16'(conv_cfg_o), 16'(cfg_data_i), "software setup");
		conv_cfg_src_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(16'(conv_cfg_o), 16'(conv_cfg_pins_i), "pin setup");
		parity_en_i <= 1'b0;
		parity_we_i <= 1'b1;
		@(posedge clk_i);
		parity_we_i <= 1'b0;
		par = 1'b0;
		send(8'h01, body, 1'b1);
		want(8'h02);
		drain();
		par = 1'b1;
		codec_mode_i <= 1'b1;
		port_sel_i <= 2'h2;
		sys_rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		conv_adc_i <= 16'($urandom);
		send(8'h00, cfgb, 1'b1);
		want(8'h00);
		drain();
		check(16'(active_port_o), 16'h0002, "port strap");
		check(16'(codec_mode_o), 16'h0001, "mode strap");
		check(16'(parity_on_o), 16'h0001, "parity default");
		dec_sample_i <= 16'($urandom);
		dec_valid_i <= 1'b1;
		@(posedge clk_i);
		dec_valid_i <= 1'b0;
		@(posedge clk_i);
		check(conv_dac_o, dec_sample_i, "decoder sample");
		body = '{8'h11};
		send(8'h02, body, 1'b1);
		// Frame sync sped up: cadence counts sync edges, not time
		repeat (160) begin
			conv_fs_i <= 1'b1;
			repeat (10) @(posedge clk_i);
			conv_fs_i <= 1'b0;
			repeat (10) @(posedge clk_i);
		end
		want(8'h01);
		drain();
		check(16'(n_err), 16'h0003, "dropped packets");
		check(16'(enc_q.size()), 16'h0000, "samples left");
		finish_test();
	end
endmodule : vocoder_packet_dispatcher_tb
